// >>> rtl/pcm_defines.vh
// Constants shared by the configuration-header capability block.
`ifndef PCM_DEFINES_VH
`define PCM_DEFINES_VH

// Byte offsets inside the configuration header.
`define PCM_OFF_MIN_GRANT 8'h3e
`define PCM_OFF_CAP_ID 8'h50
`define PCM_OFF_NEXT_PTR 8'h51
`define PCM_OFF_PM_CAP 8'h52

// Reset and fixed values.
`define PCM_RST_MIN_GRANT 8'h00
`define PCM_RST_NEXT_PTR 8'h00
`define PCM_CAP_ID_VAL 8'h01
`define PCM_CAP_VERSION 3'h2

// Field positions inside the power management capability word.
`define PCM_CAP_AUX_BIT 4
`define PCM_CAP_D1_BIT 9
`define PCM_CAP_D2_BIT 10
`define PCM_CAP_WAKE_LSB 11
`define PCM_CAP_WAKE_MSB 15

// Field positions inside the EEPROM configuration word.
`define PCM_EE_GRANT_MSB 15
`define PCM_EE_GRANT_LSB 12
`define PCM_EE_D1_BIT 6
`define PCM_EE_D2_BIT 7
`define PCM_EE_WAKE_D1_BIT 4
`define PCM_EE_WAKE_D2_BIT 5
`define PCM_EE_WAKE_D3C_BIT 3

// Timing: grant unit in nanoseconds and the core clock period.
`define PCM_GRANT_UNIT_NS 32'd250
`define PCM_CLK_PERIOD_NS 32'd20

`endif

// >>> rtl/pcm_sync.v
// Two-stage synchroniser for a level arriving from a pin.
`timescale 1ns/1ps
`default_nettype none
module pcm_sync
(
    input wire core_clk,
    input wire rst,
    input wire async_in,
    output reg sync_q
);
    // First stage; only the second stage reads it.
    reg meta_q;

    // Both stages clear on reset and then follow the pin.
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
endmodule // pcm_sync
`default_nettype wire

// >>> rtl/pcm_load_reg.v
// Field register that takes its value when the EEPROM word arrives.
`timescale 1ns/1ps
`default_nettype none
module pcm_load_reg
#(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
)
(
    input wire core_clk,
    input wire rst,
    input wire load,
    input wire [WIDTH-1:0] load_val,
    output reg [WIDTH-1:0] field_q
);
    // The field holds its reset value until a load, then keeps the load.
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            field_q <= RESET_VAL;
        end
        else if (load)
        begin
            field_q <= load_val;
        end
    end
endmodule // pcm_load_reg
`default_nettype wire

// >>> rtl/pcm_cap_regs.v
// Minimum grant, next capability pointer and power management capability.
//
// What this block does
// - Read-only minimum grant byte, 250 ns units.
// - Grant bits 7:4 loaded from EEPROM word.
// - Read-only next pointer; zero ends list.
// - Capability version field always reads 2.
// - Bit 4 reports auxiliary power from bus.
// - Bit 9, light sleep support, EEPROM loaded.
// - Bit 10, deep sleep support, EEPROM loaded.
// - Bits 15:11 mark wake-capable power states.
// - Bit 11 fixed zero, bit 14 fixed one.
// - Bits 12,13,15 from EEPROM bits 4,5,3.
`timescale 1ns/1ps
`default_nettype none
`include "pcm_defines.vh"
module pcm_cap_regs
#(
    // Width of the configuration data path in bits.
    parameter DATA_W = 32
)
(
    input wire core_clk,
    input wire rst,
    // Configuration access: one-cycle request, byte address, lanes.
    input wire cfg_req,
    input wire cfg_we,
    input wire [7:0] cfg_addr,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata_q,
    output reg cfg_ack_q,
    output reg cfg_hit_q,
    output reg cfg_wr_ignored_q,
    // EEPROM auto-load: one-cycle strobe with the configuration word.
    input wire ee_cfg_valid,
    input wire [15:0] eeprom_configuration_word,
    // Board strap: high when wake power is drawn from the bus.
    input wire aux_power_strap,
    // Live views of the held values for the rest of the device.
    output reg [7:0] minimum_grant_time_q,
    output reg [15:0] power_management_capability_q,
    output reg [15:0] min_grant_cycles_q,
    output reg autoinit_done_q
);

    // Full byte offsets at address width, so the slices below are exact.
    localparam [7:0] OFF_GRANT = `PCM_OFF_MIN_GRANT;
    localparam [7:0] OFF_PM = `PCM_OFF_CAP_ID;
    localparam [7:0] OFF_NEXT = `PCM_OFF_NEXT_PTR;
    localparam [7:0] OFF_CAP = `PCM_OFF_PM_CAP;

    // Dword index of each register group in configuration space.
    localparam [5:0] DW_GRANT = OFF_GRANT[7:2];
    localparam [5:0] DW_PM = OFF_PM[7:2];

    // Byte lane of each register inside its dword.
    localparam [1:0] LANE_GRANT = OFF_GRANT[1:0];
    localparam [1:0] LANE_NEXT = OFF_NEXT[1:0];
    localparam [1:0] LANE_CAP = OFF_CAP[1:0];

    // Synchronised strap level.
    wire aux_power_sync;
    // Loaded upper nibble of the grant byte.
    wire [3:0] grant_hi;
    // Loaded light and deep sleep support bits, deep sleep on top.
    wire [1:0] sleep_support;
    // Loaded wake bits for D3cold, D2 and D1, D3cold on top.
    wire [2:0] wake_loaded;

    // Assembled register values seen by a read.
    // Grant byte: loaded nibble over a zero nibble.
    wire [7:0] min_grant_w;
    // Next capability pointer, fixed at the end of the list.
    wire [7:0] next_ptr_w;
    // Power management capability word.
    wire [15:0] pm_cap_w;

    // Read data and decode results of the current request.
    // Decoded dword before lane masking.
    reg [31:0] rd_word;
    // High when the address falls in one of our two dwords.
    reg rd_hit;
    // All ones in each lane whose byte enable is set.
    reg [31:0] lane_mask;
    // Lane loop index.
    integer i;

    // Burst time in nanoseconds.
    wire [31:0] grant_ns;
    // Burst time in whole core clock cycles, rounded up.
    wire [31:0] grant_cyc;

    // The strap comes from a pin, so it is synchronised first.
    // A board level may change at any time; without two stages a change
    // near the clock edge could leave the capability bit undecided.
    pcm_sync u_aux_sync
    (
        .core_clk (core_clk),
        .rst (rst),
        .async_in (aux_power_strap),
        .sync_q (aux_power_sync)
    );

    // Every field register shares the one load strobe, so a load updates
    // all fields at one edge and a read never sees old and new mixed.
    // Upper grant nibble follows the EEPROM word; lower nibble stays 0.
    pcm_load_reg
    #(
        .WIDTH (4),
        .RESET_VAL (4'h0)
    )
    u_grant_hi
    (
        .core_clk (core_clk),
        .rst (rst),
        .load (ee_cfg_valid),
        .load_val (eeprom_configuration_word[`PCM_EE_GRANT_MSB:`PCM_EE_GRANT_LSB]),
        .field_q (grant_hi)
    );

    // Sleep state support bits are captured from the same word.
    pcm_load_reg
    #(
        .WIDTH (2),
        .RESET_VAL (2'h0)
    )
    u_sleep
    (
        .core_clk (core_clk),
        .rst (rst),
        .load (ee_cfg_valid),
        .load_val ({eeprom_configuration_word[`PCM_EE_D2_BIT],
                    eeprom_configuration_word[`PCM_EE_D1_BIT]}),
        .field_q (sleep_support)
    );

    // Wake bits for D3cold, D2 and D1 come from word bits 3, 5 and 4.
    pcm_load_reg
    #(
        .WIDTH (3),
        .RESET_VAL (3'h0)
    )
    u_wake
    (
        .core_clk (core_clk),
        .rst (rst),
        .load (ee_cfg_valid),
        .load_val ({eeprom_configuration_word[`PCM_EE_WAKE_D3C_BIT],
                    eeprom_configuration_word[`PCM_EE_WAKE_D2_BIT],
                    eeprom_configuration_word[`PCM_EE_WAKE_D1_BIT]}),
        .field_q (wake_loaded)
    );

    // Grant byte counts 250 ns units; low nibble has no load source.
    // The loaded value therefore moves in steps of sixteen units.
    assign min_grant_w = {grant_hi, 4'h0};

    // The capability list ends here, so the pointer is always zero.
    assign next_ptr_w = `PCM_RST_NEXT_PTR;

    // Capability word, from bit 15 down to bit 0.
    // D3hot is always wake capable and D0 never is.
    // Bits 8 down to 5 and bit 3 are reserved and read as zero.
    assign pm_cap_w = {
        wake_loaded[2],
        1'b1,
        wake_loaded[1],
        wake_loaded[0],
        1'b0,
        sleep_support[1],
        sleep_support[0],
        4'h0,
        aux_power_sync,
        1'b0,
        `PCM_CAP_VERSION
    };

    // Least burst time rounded up to whole core clock cycles.
    // Rounding up keeps a master from planning a burst that is too short.
    assign grant_ns = {24'h00_0000, min_grant_w} * `PCM_GRANT_UNIT_NS;
    assign grant_cyc = (grant_ns + `PCM_CLK_PERIOD_NS - 32'd1) / `PCM_CLK_PERIOD_NS;

    // Byte-enable mask: lanes that were not asked for read as zero.
    always @*
    begin
        lane_mask = 32'h0000_0000;
        // One lane of eight bits for each byte enable.
        for (i = 0; i < DATA_W / 8; i = i + 1)
        begin
            lane_mask[i*8 +: 8] = {8{cfg_be[i]}};
        end
    end

    // Address decode for the two dwords that this block answers.
    // Bytes of those dwords held elsewhere in the header read as zero
    // here and are merged by the header multiplexer.
    always @*
    begin
        // Defaults keep the process free of stored state.
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
        if (cfg_addr[7:2] == DW_GRANT)
        begin
            // Grant byte sits in its own lane of the dword.
            rd_hit = 1'b1;
            rd_word[LANE_GRANT*8 +: 8] = min_grant_w;
        end
        else if (cfg_addr[7:2] == DW_PM)
        begin
            // Capability identifier, next pointer and capability word.
            rd_hit = 1'b1;
            rd_word[7:0] = `PCM_CAP_ID_VAL;
            rd_word[LANE_NEXT*8 +: 8] = next_ptr_w;
            rd_word[LANE_CAP*8 +: 16] = pm_cap_w;
        end
        else
        begin
            // Any other address is not ours: no hit, data zero.
            rd_hit = 1'b0;
            rd_word = 32'h0000_0000;
        end
    end

    // Answer every request one cycle later.
    // Writes are acknowledged but never change any stored value.
    // A write to one of our dwords raises the ignored flag, so the host
    // side can tell a refused write from an access that missed.
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            // Reset: all answer outputs low.
            cfg_rdata_q <= 32'h0000_0000;
            cfg_ack_q <= 1'b0;
            cfg_hit_q <= 1'b0;
            cfg_wr_ignored_q <= 1'b0;
        end
        else if (cfg_req)
        begin
            // Acknowledge and report whether the address was ours.
            cfg_ack_q <= 1'b1;
            cfg_hit_q <= rd_hit;
            if (cfg_we)
            begin
                // Write data is dropped; the read data path stays clear.
                cfg_rdata_q <= 32'h0000_0000;
                cfg_wr_ignored_q <= rd_hit;
            end
            else
            begin
                // Read returns only the enabled lanes.
                cfg_rdata_q <= rd_word & lane_mask;
                cfg_wr_ignored_q <= 1'b0;
            end
        end
        else
        begin
            // No request: answer strobes drop, data returns to zero.
            cfg_rdata_q <= 32'h0000_0000;
            cfg_ack_q <= 1'b0;
            cfg_hit_q <= 1'b0;
            cfg_wr_ignored_q <= 1'b0;
        end
    end

    // Live copies of the register values for the bus master and
    // power logic, plus the burst time converted to clock cycles.
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            // Reset: the copies start from zero until the first edge after.
            minimum_grant_time_q <= `PCM_RST_MIN_GRANT;
            power_management_capability_q <= 16'h0000;
            min_grant_cycles_q <= 16'h0000;
        end
        else
        begin
            minimum_grant_time_q <= min_grant_w;
            power_management_capability_q <= pm_cap_w;
            min_grant_cycles_q <= grant_cyc[15:0];
        end
    end

    // Auto-initialisation done flag: set by the first EEPROM load and
    // held until reset, so software can tell loaded from default values.
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            // Reset: nothing has been loaded yet.
            autoinit_done_q <= 1'b0;
        end
        else if (ee_cfg_valid)
        begin
            autoinit_done_q <= 1'b1;
        end
    end

    // The write data bus is deliberately unused: every register here
    // is read only. Its bits are folded away to keep the port honest.
    wire unused_wdata;
    assign unused_wdata = ^cfg_wdata;

endmodule // pcm_cap_regs
`default_nettype wire

// >>> dv/pcm_cap_properties.sv
// Concurrent checks on the capability register block ports.
`timescale 1ns/1ps
`default_nettype none
module pcm_cap_properties
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_rdata_q,
    input wire logic cfg_ack_q,
    input wire logic cfg_hit_q,
    input wire logic cfg_wr_ignored_q,
    input wire logic ee_cfg_valid,
    input wire logic [15:0] eeprom_configuration_word,
    input wire logic aux_power_strap,
    input wire logic [7:0] minimum_grant_time_q,
    input wire logic [15:0] power_management_capability_q,
    input wire logic [15:0] min_grant_cycles_q,
    input wire logic autoinit_done_q
);
    // High when the access addresses one of the two dwords of this block.
    wire logic ours = (cfg_addr[7:2] == 6'h0f) || (cfg_addr[7:2] == 6'h14);
    wire logic [15:0] pm = power_management_capability_q;
    logic [15:0] w1_q;
    logic [15:0] w2_q;
    // Delays the EEPROM word so loads can be compared two edges later.
    always @(posedge core_clk)
    begin
        w1_q <= eeprom_configuration_word;
        w2_q <= w1_q;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_ack_one_cycle: assert property (cfg_ack_q == $past(cfg_req))
        else $error("ack not one cycle after request");
    a_write_ignored: assert property (cfg_req && cfg_we && ours |=> cfg_wr_ignored_q && cfg_rdata_q == 32'h0000_0000)
        else $error("write to read-only word not refused");
    a_unmapped_zero: assert property (cfg_req && !ours |=> !cfg_hit_q && cfg_rdata_q == 32'h0000_0000)
        else $error("unmapped access answered");
    a_next_ptr_zero: assert property (cfg_req && !cfg_we && cfg_addr[7:2] == 6'h14 |=> cfg_hit_q && cfg_rdata_q[15:8] == 8'h00)
        else $error("next pointer not zero");
    a_version_field: assert property (autoinit_done_q && $past(autoinit_done_q) |-> pm[2:0] == 3'h2)
        else $error("version field wrong");
    a_fixed_wake_bits: assert property (autoinit_done_q && $past(autoinit_done_q) |-> !pm[11] && pm[14])
        else $error("fixed wake bits wrong");
    a_reserved_zero: assert property (autoinit_done_q && $past(autoinit_done_q) |-> pm[3] == 1'b0 && pm[8:5] == 4'h0)
        else $error("reserved capability bits set");
    a_wake_load: assert property (ee_cfg_valid ##1 !ee_cfg_valid |=> {pm[15], pm[13], pm[12], pm[10], pm[9]} == {w2_q[3], w2_q[5], w2_q[4], w2_q[7], w2_q[6]})
        else $error("capability fields not loaded");
    a_grant_load: assert property (ee_cfg_valid ##1 !ee_cfg_valid |=> minimum_grant_time_q == {w2_q[15:12], 4'h0})
        else $error("grant nibble not loaded");
    a_grant_cycles: assert property (autoinit_done_q && minimum_grant_time_q == $past(minimum_grant_time_q, 2) |-> min_grant_cycles_q == ({8'h00, minimum_grant_time_q} * 16'd250 + 16'd19) / 16'd20)
        else $error("grant cycle count wrong");
    a_aux_follows: assert property ($stable(aux_power_strap) [*8] |-> pm[4] == aux_power_strap)
        else $error("aux power bit does not follow strap");
endmodule // pcm_cap_properties
bind pcm_cap_regs pcm_cap_properties u_props (.core_clk, .rst, .cfg_req, .cfg_we, .cfg_addr,
    .cfg_be, .cfg_rdata_q, .cfg_ack_q, .cfg_hit_q, .cfg_wr_ignored_q, .ee_cfg_valid,
    .eeprom_configuration_word, .aux_power_strap, .minimum_grant_time_q,
    .power_management_capability_q, .min_grant_cycles_q, .autoinit_done_q);
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the capability register block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin $display("Error t=%0t got %h exp %h", $time, a, b); miscompares++; end end
module tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_req = 1'b0;
    logic cfg_we = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0000_0000;
    logic ee_cfg_valid = 1'b0;
    logic [15:0] eeprom_configuration_word = 16'h0000;
    logic aux_power_strap = 1'b0;
    logic [31:0] cfg_rdata_q;
    logic cfg_ack_q, cfg_hit_q, cfg_wr_ignored_q, autoinit_done_q;
    logic [7:0] minimum_grant_time_q;
    logic [15:0] power_management_capability_q, min_grant_cycles_q;
    logic [15:0] last_w = 16'h0000;
    logic [31:0] rd;
    int miscompares = 0;
    int num_checks = 0;
    // The 50 MHz core clock.
    always #10 core_clk = ~core_clk;
    pcm_cap_regs dut (.core_clk, .rst, .cfg_req, .cfg_we, .cfg_addr, .cfg_be, .cfg_wdata,
        .cfg_rdata_q, .cfg_ack_q, .cfg_hit_q, .cfg_wr_ignored_q, .ee_cfg_valid,
        .eeprom_configuration_word, .aux_power_strap, .minimum_grant_time_q,
        .power_management_capability_q, .min_grant_cycles_q, .autoinit_done_q);
    // Expected capability word for an EEPROM word and strap level.
    function automatic logic [15:0] cap(input logic [15:0] w, input logic s);
        return {w[3], 1'b1, w[5], w[4], 1'b0, w[7], w[6], 4'h0, s, 1'b0, 3'h2};
    endfunction
    // One access; the answer is sampled in the single cycle it stands.
    task automatic cfg(input logic we, input logic [7:0] addr, input logic [3:0] be);
        logic hit;
        hit = (addr[7:2] == 6'h0f) || (addr[7:2] == 6'h14);
        @(posedge core_clk);
        cfg_req <= 1'b1;
        cfg_we <= we;
        cfg_addr <= addr;
        cfg_be <= be;
        cfg_wdata <= {32{we}};
        @(posedge core_clk);
        cfg_req <= 1'b0;
        #1;
        `CHK({cfg_ack_q, cfg_hit_q, cfg_wr_ignored_q}, {1'b1, hit, we & hit})
        rd = cfg_rdata_q;
    endtask
    // Values seen before any EEPROM load.
    task automatic t_reset_values;
        cfg(1'b0, 8'h50, 4'hf);
        `CHK(rd, {16'h4002, 16'h0001})
        cfg(1'b0, 8'h3e, 4'hf);
        `CHK(rd, 32'h0000_0000)
        `CHK(autoinit_done_q, 1'b0)
        `CHK(power_management_capability_q, 16'h4002)
    endtask
    // Loads of several words; the word changes right after it is taken.
    task automatic t_load;
        logic [15:0] words [4];
        words = '{16'hffff, 16'h0000, 16'ha5c3, 16'h5a3c};
        foreach (words[i])
        begin
            @(posedge core_clk);
            ee_cfg_valid <= 1'b1;
            eeprom_configuration_word <= words[i];
            @(posedge core_clk);
            ee_cfg_valid <= 1'b0;
            eeprom_configuration_word <= ~words[i];
            last_w = words[i];
            cfg(1'b0, 8'h50, 4'hf);
            `CHK(rd, {cap(last_w, 1'b0), 16'h0001})
            cfg(1'b0, 8'h3c, 4'hf);
            `CHK(rd, {8'h00, last_w[15:12], 4'h0, 16'h0000})
            `CHK(minimum_grant_time_q, {last_w[15:12], 4'h0})
            `CHK(min_grant_cycles_q, 16'((last_w[15:12] * 16 * 250 + 19) / 20))
            `CHK(autoinit_done_q, 1'b1)
            `CHK(power_management_capability_q, cap(last_w, 1'b0))
        end
    endtask
    // Writes are refused, lanes mask, an unmapped word reads zero.
    task automatic t_writes;
        cfg(1'b1, 8'h50, 4'hf);
        `CHK(rd, 32'h0000_0000)
        cfg(1'b1, 8'h3c, 4'hf);
        cfg(1'b0, 8'h50, 4'h1);
        `CHK(rd, 32'h0000_0001)
        cfg(1'b0, 8'h40, 4'hf);
        `CHK(rd, 32'h0000_0000)
        cfg(1'b0, 8'h50, 4'hf);
        `CHK(rd, {cap(last_w, 1'b0), 16'h0001})
    endtask
    // The auxiliary power bit follows the strap once it settles.
    task automatic t_strap;
        @(posedge core_clk);
        aux_power_strap <= 1'b1;
        repeat (8) @(posedge core_clk);
        cfg(1'b0, 8'h52, 4'hc);
        `CHK(rd, {cap(last_w, 1'b1), 16'h0000})
        `CHK(power_management_capability_q, cap(last_w, 1'b1))
    endtask
    // Prints the verdict and ends the run.
    task automatic results;
        if (miscompares == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence after three cycles of reset.
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        t_reset_values();
        t_load();
        t_writes();
        t_strap();
        results();
    end
    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        results();
    end
endmodule // tb
`default_nettype wire
